// file: sod_defs.vh
// Constants for the single-operand instruction decode and execute block.
// Assumes inclusion by bare name from the design file.
`ifndef SOD_DEFS_VH
`define SOD_DEFS_VH
////////////////////////////////////////////////////////////////////////////
// Bus register byte addresses
`define SOD_A_INSN 8'h00
`define SOD_A_CTRL 8'h04
`define SOD_A_STAT 8'h08
`define SOD_A_SEL 8'h0c
`define SOD_A_DATA 8'h10
`define SOD_A_STATUS 8'h14
`define SOD_A_LINK 8'h18
`define SOD_A_SSR 8'h1c
`define SOD_A_SPC 8'h20
`define SOD_A_ACCH 8'h24
`define SOD_A_ACCL 8'h28
`define SOD_A_FCW 8'h2c
`define SOD_A_PC 8'h30
// Selector for indirect register window: bit 4 picks float file
`define SOD_SEL_FLT 4
// Fixed full instruction codes
`define SOD_OP_RET_SUB 16'h000b
`define SOD_OP_RET_EXC 16'h002b
`define SOD_OP_ACC_CLR 16'h0028
`define SOD_OP_BANK_TGL 16'hfbfd
`define SOD_OP_SIZE_TGL 16'hf3fd
// Low bytes of register forms, top nibble 4 for integer and f for float forms
`define SOD_HI_GPR 4'h4
`define SOD_HI_FLT 4'hf
`define SOD_LO_NONNEG 8'h11
`define SOD_LO_POS 8'h15
`define SOD_LO_DT 8'h10
`define SOD_LO_ROTATE_LEFT 8'h04
`define SOD_LO_ROTATE_RIGHT 8'h05
`define SOD_LO_ROTATE_LEFT_VIA_FLAG 8'h24
`define SOD_LO_ROTATE_RIGHT_VIA_FLAG 8'h25
`define SOD_LO_ARITH_SHIFT_LEFT 8'h20
`define SOD_LO_ARITH_SHIFT_RIGHT 8'h21
`define SOD_LO_LOGIC_SHIFT_LEFT 8'h00
`define SOD_LO_LOGIC_SHIFT_RIGHT 8'h01
`define SOD_LO_L2 8'h08
`define SOD_LO_R2 8'h09
`define SOD_LO_L8 8'h18
`define SOD_LO_R8 8'h19
`define SOD_LO_L16 8'h28
`define SOD_LO_R16 8'h29
`define SOD_LO_FLOAT_ABSOLUTE 8'h5d
`define SOD_LO_FLOAT_NEGATE 8'h4d
// Masks and fields
`define SOD_ABS_MASK 32'h7fff_ffff
`define SOD_NEG_MASK 32'h8000_0000
`define SOD_FCW_BANK 21
`define SOD_FCW_SIZE 20
`define SOD_SW_PRIV 30
`define SOD_SW_FLAG 0
`define SOD_SW_RESET 32'h7000_00f0
`define SOD_FCW_RESET 32'h0004_0001
// Status register bits
`define SOD_ST_BRANCH 0
`define SOD_ST_ILLEGAL 1
`define SOD_ST_UNKNOWN 2
`endif

// file: sod_core.v
// Single-operand instruction decode and execute block with AHB-Lite slave.
// Assumes one 20 MHz clock, single word transfers, and an OKAY-only bus.
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`include "sod_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Function
// (RULE_01) Code 000b: delayed branch, counter loaded from return link.
// (RULE_02) Code 002b, privileged only: delayed branch restoring status, counter.
// (RULE_03) Code 0028 clears both accumulator halves; flag unchanged.
// (RULE_04) fbfd toggles float bank select; f3fd toggles transfer size mode.
// (RULE_05) cmp_nonneg: flag set when register signed value is at least zero.
// (RULE_06) cmp_positive: flag set when register signed value exceeds zero.
// (RULE_07) decrement_and_test: register minus one, flag set when result zero.
// (RULE_08) Rotates move outgoing bit to flag; via-flag forms insert old flag.
// (RULE_09) One-bit shifts move outgoing bit to flag; zero or sign fill.
// (RULE_10) Left shifts by 2, 8 or 16 with zero fill; flag unchanged.
// (RULE_11) Logical right shifts by 2, 8 or 16; flag unchanged.
// (RULE_12) Single float absolute clears bit 31 only.
// (RULE_13) Single float negate inverts bit 31 only.
// (RULE_14) Double float absolute clears pair sign bit only.
// (RULE_15) Double float negate inverts pair sign bit only.
// (RULE_16) Register field is instruction bits 11 to 8.
// (RULE_17) Double forms use bits 11 to 9 as even pair; bit 8 zero.
module sod_core (
  // Bus clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Branch notice to the fetch side
  output reg branch_pending,
  output reg [31:0] branch_target
);

  // Register files and architectural state
  reg [31:0] gpr [0:15];
  reg [31:0] fpr [0:15];
  reg [31:0] status_word;
  reg [31:0] return_link;
  reg [31:0] saved_status_word;
  reg [31:0] saved_counter_value;
  reg [31:0] acc_high;
  reg [31:0] acc_low;
  reg [31:0] float_ctrl_word;
  reg [31:0] prog_counter;
  reg [4:0] sel;
  reg [2:0] stat;
  // Data phase capture
  reg dp_wr;
  reg dp_rd;
  reg [7:0] dp_addr;
  integer i;

  ////////////////////////////////////////////////////////////////////////
  // Register field helpers
  function [3:0] reg_field;
    input [15:0] insn;
    begin
      reg_field = insn[11:8]; // [RULE_16]
    end
  endfunction

  function [3:0] pair_base;
    input [15:0] insn;
    begin
      pair_base = {insn[11:9], 1'b0}; // [RULE_17]
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Address phase capture
  wire take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr <= take && hwrite;
      dp_rd <= take && !hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Instruction decode from a write to the instruction register
  wire insn_go = dp_wr && (dp_addr == `SOD_A_INSN);
  wire [15:0] insn = hwdata[15:0];
  wire [3:0] rn = reg_field(insn);
  wire [3:0] dn = pair_base(insn);
  wire [7:0] lo = insn[7:0];
  wire is_gpr = insn[15:12] == `SOD_HI_GPR;
  wire is_flt = insn[15:12] == `SOD_HI_FLT;
  wire [31:0] rv = gpr[rn];
  wire old_t = status_word[`SOD_SW_FLAG];
  wire priv = status_word[`SOD_SW_PRIV];

  reg [31:0] g_res;
  reg g_we;
  reg t_new;
  reg t_we;
  reg known;

  // Integer single-operand forms
  always @* begin
    g_res = rv;
    g_we = 1'b0;
    t_new = old_t;
    t_we = 1'b0;
    known = 1'b1;
    if (is_gpr) begin
      case (lo)
        `SOD_LO_NONNEG: begin
          t_new = ~rv[31]; // [RULE_05]
          t_we = 1'b1;
        end
        `SOD_LO_POS: begin
          t_new = ~rv[31] && (rv != 32'h0000_0000); // [RULE_06]
          t_we = 1'b1;
        end
        `SOD_LO_DT: begin
          g_res = rv - 32'h0000_0001; // [RULE_07]
          g_we = 1'b1;
          t_new = (rv == 32'h0000_0001); // [RULE_07]
          t_we = 1'b1;
        end
        `SOD_LO_ROTATE_LEFT: begin
          g_res = {rv[30:0], rv[31]}; // [RULE_08]
          g_we = 1'b1;
          t_new = rv[31];
          t_we = 1'b1;
        end
        `SOD_LO_ROTATE_RIGHT: begin
          g_res = {rv[0], rv[31:1]}; // [RULE_08]
          g_we = 1'b1;
          t_new = rv[0];
          t_we = 1'b1;
        end
        `SOD_LO_ROTATE_LEFT_VIA_FLAG: begin
          g_res = {rv[30:0], old_t}; // [RULE_08]
          g_we = 1'b1;
          t_new = rv[31];
          t_we = 1'b1;
        end
        `SOD_LO_ROTATE_RIGHT_VIA_FLAG: begin
          g_res = {old_t, rv[31:1]}; // [RULE_08]
          g_we = 1'b1;
          t_new = rv[0];
          t_we = 1'b1;
        end
        `SOD_LO_ARITH_SHIFT_LEFT, `SOD_LO_LOGIC_SHIFT_LEFT: begin
          g_res = {rv[30:0], 1'b0}; // [RULE_09]
          g_we = 1'b1;
          t_new = rv[31];
          t_we = 1'b1;
        end
        `SOD_LO_ARITH_SHIFT_RIGHT: begin
          g_res = {rv[31], rv[31:1]}; // [RULE_09]
          g_we = 1'b1;
          t_new = rv[0];
          t_we = 1'b1;
        end
        `SOD_LO_LOGIC_SHIFT_RIGHT: begin
          g_res = {1'b0, rv[31:1]}; // [RULE_09]
          g_we = 1'b1;
          t_new = rv[0];
          t_we = 1'b1;
        end
        `SOD_LO_L2: begin
          g_res = {rv[29:0], 2'b00}; // [RULE_10]
          g_we = 1'b1;
        end
        `SOD_LO_L8: begin
          g_res = {rv[23:0], 8'h00}; // [RULE_10]
          g_we = 1'b1;
        end
        `SOD_LO_L16: begin
          g_res = {rv[15:0], 16'h0000}; // [RULE_10]
          g_we = 1'b1;
        end
        `SOD_LO_R2: begin
          g_res = {2'b00, rv[31:2]}; // [RULE_11]
          g_we = 1'b1;
        end
        `SOD_LO_R8: begin
          g_res = {8'h00, rv[31:8]}; // [RULE_11]
          g_we = 1'b1;
        end
        `SOD_LO_R16: begin
          g_res = {16'h0000, rv[31:16]}; // [RULE_11]
          g_we = 1'b1;
        end
        default: known = 1'b0;
      endcase
    end else begin
      known = 1'b0;
    end
  end

  // Float sign forms; double pair needs bit 8 clear
  wire f_abs_s = is_flt && (lo == `SOD_LO_FLOAT_ABSOLUTE);
  wire f_neg_s = is_flt && (lo == `SOD_LO_FLOAT_NEGATE);
  wire dbl = float_ctrl_word[`SOD_FCW_SIZE] && !insn[8]; // [RULE_17]
  wire f_any = f_abs_s || f_neg_s;
  wire ctl_hit = (insn == `SOD_OP_RET_SUB) || (insn == `SOD_OP_RET_EXC) ||
    (insn == `SOD_OP_ACC_CLR) || (insn == `SOD_OP_BANK_TGL) ||
    (insn == `SOD_OP_SIZE_TGL);

  ////////////////////////////////////////////////////////////////////////
  // Architectural state update and software register writes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 16; i = i + 1) begin
        gpr[i] <= 32'h0000_0000;
        fpr[i] <= 32'h0000_0000;
      end
      status_word <= `SOD_SW_RESET;
      return_link <= 32'h0000_0000;
      saved_status_word <= 32'h0000_0000;
      saved_counter_value <= 32'h0000_0000;
      acc_high <= 32'h0000_0000;
      acc_low <= 32'h0000_0000;
      float_ctrl_word <= `SOD_FCW_RESET;
      prog_counter <= 32'h0000_0000;
      sel <= 5'h00;
      stat <= 3'b000;
      branch_pending <= 1'b0;
      branch_target <= 32'h0000_0000;
    end else if (insn_go) begin
      branch_pending <= 1'b0;
      stat <= 3'b000;
      prog_counter <= prog_counter + 32'h0000_0002;
      if (g_we)
        gpr[rn] <= g_res;
      if (t_we)
        status_word[`SOD_SW_FLAG] <= t_new;
      stat[`SOD_ST_UNKNOWN] <= !(known || f_any || ctl_hit);
      if (insn == `SOD_OP_RET_SUB) begin
        branch_pending <= 1'b1; // [RULE_01]
        branch_target <= return_link;
        stat[`SOD_ST_BRANCH] <= 1'b1;
      end
      if (insn == `SOD_OP_RET_EXC) begin
        if (priv) begin
          branch_pending <= 1'b1; // [RULE_02]
          branch_target <= saved_counter_value;
          status_word <= saved_status_word;
          stat[`SOD_ST_BRANCH] <= 1'b1;
        end else begin
          stat[`SOD_ST_ILLEGAL] <= 1'b1; // [RULE_02]
        end
      end
      if (insn == `SOD_OP_ACC_CLR) begin
        acc_high <= 32'h0000_0000; // [RULE_03]
        acc_low <= 32'h0000_0000;
      end
      if (insn == `SOD_OP_BANK_TGL)
        float_ctrl_word[`SOD_FCW_BANK] <= ~float_ctrl_word[`SOD_FCW_BANK];
      if (insn == `SOD_OP_SIZE_TGL) // [RULE_04]
        float_ctrl_word[`SOD_FCW_SIZE] <= ~float_ctrl_word[`SOD_FCW_SIZE];
      if (f_abs_s && !dbl)
        fpr[rn] <= fpr[rn] & `SOD_ABS_MASK; // [RULE_12]
      if (f_neg_s && !dbl)
        fpr[rn] <= fpr[rn] ^ `SOD_NEG_MASK; // [RULE_13]
      if (f_abs_s && dbl)
        fpr[dn] <= fpr[dn] & `SOD_ABS_MASK; // [RULE_14]
      if (f_neg_s && dbl)
        fpr[dn] <= fpr[dn] ^ `SOD_NEG_MASK; // [RULE_15]
    end else if (dp_wr) begin
      branch_pending <= 1'b0;
      case (dp_addr)
        `SOD_A_SEL: sel <= hwdata[4:0];
        `SOD_A_DATA: begin
          if (sel[`SOD_SEL_FLT])
            fpr[sel[3:0]] <= hwdata;
          else
            gpr[sel[3:0]] <= hwdata;
        end
        `SOD_A_STATUS: status_word <= hwdata;
        `SOD_A_LINK: return_link <= hwdata;
        `SOD_A_SSR: saved_status_word <= hwdata;
        `SOD_A_SPC: saved_counter_value <= hwdata;
        `SOD_A_ACCH: acc_high <= hwdata;
        `SOD_A_ACCL: acc_low <= hwdata;
        `SOD_A_FCW: float_ctrl_word <= hwdata;
        `SOD_A_PC: prog_counter <= hwdata;
        default: ;
      endcase
    end else begin
      branch_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered in the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      case (haddr[7:0])
        `SOD_A_STAT: hrdata <= {29'h0000_0000, stat};
        `SOD_A_SEL: hrdata <= {27'h0000_000, sel};
        `SOD_A_DATA: hrdata <= sel[`SOD_SEL_FLT] ? fpr[sel[3:0]] :
          gpr[sel[3:0]];
        `SOD_A_STATUS: hrdata <= status_word;
        `SOD_A_LINK: hrdata <= return_link;
        `SOD_A_SSR: hrdata <= saved_status_word;
        `SOD_A_SPC: hrdata <= saved_counter_value;
        `SOD_A_ACCH: hrdata <= acc_high;
        `SOD_A_ACCL: hrdata <= acc_low;
        `SOD_A_FCW: hrdata <= float_ctrl_word;
        `SOD_A_PC: hrdata <= prog_counter;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // sod_core

// file: sod_monitor.sv
// Concurrent checks on the single-operand decode block's bus and branch ports.
// Assumes one clock, hreadyout as the bus hready, and INSN writes execute.
`include "sod_defs.vh"
////////////////////////////////////////////////////////////////////////////
module sod_monitor (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // Branch notice
  input wire branch_pending,
  input wire [31:0] branch_target
);
  logic ph_q;
  logic exec_q;
  logic [15:0] code_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Track an instruction word from address phase to its execute edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      exec_q <= 1'b0;
      code_q <= 16'h0;
    end else begin
      ph_q <= hsel && hready && htrans[1] && hwrite &&
              haddr[7:0] == `SOD_A_INSN;
      exec_q <= ph_q;
      if (ph_q) code_q <= hwdata[15:0];
    end
  end
  sequence s_rd_acc;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_rsv_rd;
    s_rd_acc ##0 haddr[7:0] == 8'h04;
  endsequence
  a_ready_always: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_branch_pulse: assert property (branch_pending |=> !branch_pending)
    else $error("branch notice longer than one cycle");
  a_branch_cause: assert property (
    branch_pending |-> exec_q &&
    (code_q == `SOD_OP_RET_SUB || code_q == `SOD_OP_RET_EXC))
    else $error("branch without a return instruction");
  a_rts_branch: assert property (
    exec_q && code_q == `SOD_OP_RET_SUB |-> branch_pending)
    else $error("subroutine return did not branch");
  a_reserved_read: assert property (s_rsv_rd |=> hrdata == 32'h0)
    else $error("reserved read not zero");
  a_target_hold: assert property ($changed(branch_target) |-> branch_pending)
    else $error("branch target moved without a branch");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(hsel && hready
    && htrans[1] && !hwrite))
    else $error("read data moved without a read");
endmodule // sod_monitor
bind sod_core sod_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .branch_pending(branch_pending), .branch_target(branch_target));

// file: sod_core_bench.sv
// Self-checking bench for the single-operand decode block.
// Assumes a zero-wait AHB-Lite slave and the register map of sod_defs.vh.
`include "sod_defs.vh"
////////////////////////////////////////////////////////////////////////////
module sod_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] n;
  logic [73:0] tbl [18];
  wire hreadyout, hresp, branch_pending;
  wire [31:0] hrdata, branch_target;
  int num_errors, checks;
  sod_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .branch_pending(branch_pending),
    .branch_target(branch_target));
  // Clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // One single transfer: address phase, then data phase
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rv, exp);
  endtask
  task automatic exec(input logic [15:0] op);
    xfer(`SOD_A_INSN, 1'b1, {16'h0, op});
  endtask
  task automatic fset(input logic [4:0] i, input logic [31:0] v);
    xfer(`SOD_A_SEL, 1'b1, {27'h0, i});
    xfer(`SOD_A_DATA, 1'b1, v);
  endtask
  task automatic fchk(input logic [4:0] i, input logic [31:0] v);
    xfer(`SOD_A_SEL, 1'b1, {27'h0, i});
    rdchk(`SOD_A_DATA, v);
  endtask
  task automatic results;
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #1ms;
    num_errors++;
    results();
  end
  // Tests
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; hwrite = 1'b0;
    htrans = 2'b00; hsize = 3'b010; hwdata = 32'h0;
    num_errors = 0; checks = 0;
    // Low byte, value in, flag in, value out, flag out
    tbl = '{{8'h11,32'h0,1'b0,32'h0,1'b1},
      {8'h11,32'h80000000,1'b1,32'h80000000,1'b0},
      {8'h15,32'h0,1'b1,32'h0,1'b0}, {8'h15,32'h1,1'b0,32'h1,1'b1},
      {8'h10,32'h1,1'b0,32'h0,1'b1}, {8'h10,32'h0,1'b1,32'hffffffff,1'b0},
      {8'h04,32'h80000001,1'b0,32'h3,1'b1},
      {8'h05,32'h1,1'b0,32'h80000000,1'b1},
      {8'h24,32'h40000000,1'b1,32'h80000001,1'b0},
      {8'h25,32'h2,1'b1,32'h80000001,1'b0},
      {8'h20,32'hc0000001,1'b0,32'h80000002,1'b1},
      {8'h21,32'h80000003,1'b0,32'hc0000001,1'b1},
      {8'h00,32'h40000000,1'b1,32'h80000000,1'b0},
      {8'h01,32'h80000003,1'b0,32'h40000001,1'b1},
      {8'h08,32'hc0000001,1'b1,32'h4,1'b1},
      {8'h18,32'h12345678,1'b0,32'h34567800,1'b0},
      {8'h28,32'h12345678,1'b1,32'h56780000,1'b1},
      {8'h19,32'h80000000,1'b1,32'h00800000,1'b1}};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(`SOD_A_STATUS, `SOD_SW_RESET);
    rdchk(`SOD_A_FCW, `SOD_FCW_RESET);
    rdchk(8'h04, 32'h0);
    for (int i = 0; i < 18; i++) begin
      n = 4'(i);
      fset({1'b0, n}, tbl[i][65:34]);
      xfer(`SOD_A_STATUS, 1'b1, `SOD_SW_RESET | {31'h0, tbl[i][33]});
      exec({4'h4, n, tbl[i][73:66]});
      rdchk(`SOD_A_DATA, tbl[i][32:1]);
      rdchk(`SOD_A_STATUS, `SOD_SW_RESET | {31'h0, tbl[i][0]});
    end
    // Right shifts by two and sixteen, with the flag checked unchanged after the shift by two
    fset(5'h06, 32'h80000003);
    exec(16'h4609);
    fchk(5'h06, 32'h20000000);
    rdchk(`SOD_A_STATUS, 32'h700000f1);
    rdchk(`SOD_A_SEL, 32'h00000006);
    fset(5'h07, 32'h12345678);
    exec(16'h4729);
    fchk(5'h07, 32'h00001234);
    // Undecoded code flags itself and still advances the counter
    xfer(`SOD_A_PC, 1'b1, 32'h00000100);
    exec(16'h0009);
    rdchk(`SOD_A_STAT, 32'h00000004);
    rdchk(`SOD_A_PC, 32'h00000102);
    fset(5'h15, 32'hc0000001);
    exec(16'hf55d);
    fchk(5'h15, 32'h40000001);
    fset(5'h13, 32'h12345678);
    exec(16'hf34d);
    fchk(5'h13, 32'h92345678);
    exec(`SOD_OP_SIZE_TGL);
    rdchk(`SOD_A_FCW, 32'h00140001);
    fset(5'h12, 32'h80000000);
    fset(5'h13, 32'hffffffff);
    exec(16'hf25d);
    fchk(5'h12, 32'h0);
    fchk(5'h13, 32'hffffffff);
    fset(5'h14, 32'h3ff00000);
    fset(5'h15, 32'h0);
    exec(16'hf44d);
    fchk(5'h14, 32'hbff00000);
    fchk(5'h15, 32'h0);
    exec(`SOD_OP_BANK_TGL);
    rdchk(`SOD_A_FCW, 32'h00340001);
    xfer(`SOD_A_ACCH, 1'b1, 32'h5a5a5a5a);
    xfer(`SOD_A_ACCL, 1'b1, 32'ha5a5a5a5);
    xfer(`SOD_A_STATUS, 1'b1, 32'h700000f1);
    exec(`SOD_OP_ACC_CLR);
    rdchk(`SOD_A_ACCH, 32'h0);
    rdchk(`SOD_A_ACCL, 32'h0);
    rdchk(`SOD_A_STATUS, 32'h700000f1);
    xfer(`SOD_A_LINK, 1'b1, 32'h00001230);
    exec(`SOD_OP_RET_SUB);
    @(negedge hclk);
    chk({31'h0, branch_pending}, 32'h1);
    chk(branch_target, 32'h00001230);
    @(posedge hclk);
    rdchk(`SOD_A_STAT, 32'h1);
    xfer(`SOD_A_SSR, 1'b1, 32'h40000301);
    xfer(`SOD_A_SPC, 1'b1, 32'h00004440);
    exec(`SOD_OP_RET_EXC);
    @(negedge hclk);
    chk({31'h0, branch_pending}, 32'h1);
    chk(branch_target, 32'h00004440);
    @(posedge hclk);
    rdchk(`SOD_A_STATUS, 32'h40000301);
    xfer(`SOD_A_STATUS, 1'b1, 32'h300000f0);
    exec(`SOD_OP_RET_EXC);
    @(negedge hclk);
    chk({31'h0, branch_pending}, 32'h0);
    @(posedge hclk);
    rdchk(`SOD_A_STAT, 32'h2);
    xfer(`SOD_A_STAT, 1'b1, 32'hffffffff);
    rdchk(`SOD_A_STAT, 32'h2);
    rdchk(`SOD_A_STATUS, 32'h300000f0);
    results();
  end
endmodule // sod_core_bench
